/* File: hw/dtsp_map.vh */
// Constants of the debug trace and serial port
`ifndef DTSP_MAP_VH
`define DTSP_MAP_VH

// ----------------------------------------------------------------------
// Serial debug port
// ----------------------------------------------------------------------
`define DTSP_FRAME_W 17
`define DTSP_BITCNT_W 5
`define DTSP_OUT_DELAY_NS 10
`define DTSP_OUT_DELAY_CYC ((`DTSP_OUT_DELAY_NS * 200) / 1000)

// ----------------------------------------------------------------------
// Trace port
// ----------------------------------------------------------------------
`define DTSP_STATUS_W 4
`define DTSP_STATUS_HALT 4'hF
`define DTSP_STATUS_IDLE 4'h0
`define DTSP_DATA_IDLE 4'h0
`define DTSP_START_C 4'hC
`define DTSP_START_D 4'hD
`define DTSP_START_F 4'hF

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DTSP_QUIET_RST 1'b0
`define DTSP_DSO_RST 1'b0

`endif

/* File: hw/dtsp_sync.v */
// Three-stage pin synchroniser with agreement filter, one per bit
module dtsp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire srst,
  input wire clkEn,
  input wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;

  // ----------------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------------
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg stageA_reg; // Metastability catcher, read by stage B only
      reg stageB_reg; // Second stage
      reg stageC_reg; // Third stage
      reg level_reg; // Accepted level

      // Shift in and accept a level once stages B and C agree
      always @(posedge core_clk) begin
        if (srst) begin
          stageA_reg <= RST_VAL[i];
          stageB_reg <= RST_VAL[i];
          stageC_reg <= RST_VAL[i];
          level_reg <= RST_VAL[i];
        end else if (clkEn) begin
          stageA_reg <= pinIn[i];
          stageB_reg <= stageA_reg;
          stageC_reg <= stageB_reg;
          if (stageB_reg == stageC_reg) begin
            level_reg <= stageC_reg;
          end
        end
      end

      assign syncOut[i] = level_reg;
    end
  endgenerate

endmodule // dtsp_sync

/* File: hw/dtsp_buf2.v */
// Two-entry valid/ready buffer for captured trace data
module dtsp_buf2 #(
  parameter WIDTH = 4
) (
  input wire core_clk,
  input wire srst,
  input wire clkEn,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);

  reg [WIDTH-1:0] mem_reg [0:1]; // Storage entries
  reg wrPtr_reg; // Write index
  reg rdPtr_reg; // Read index
  reg [1:0] count_reg; // Number of held words
  wire doPush; // Word accepted
  wire doPop; // Word delivered

  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outValid = (count_reg != 2'h0);
  assign outData = mem_reg[rdPtr_reg];

  // ----------------------------------------------------------------------
  // Pointers, count and storage
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
      inReady <= 1'b1;
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      if (doPush) begin
        mem_reg[wrPtr_reg] <= inData;
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (doPop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      // Ready drops only when both entries hold words
      case ({doPush, doPop})
        2'b10: begin
          count_reg <= count_reg + 2'h1;
          inReady <= (count_reg == 2'h0);
        end
        2'b01: begin
          count_reg <= count_reg - 2'h1;
          inReady <= 1'b1;
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

endmodule // dtsp_buf2

/* File: hw/dtsp_top.v */
// Debug serial port and real-time trace port of the processor core
//
// Operation
// - Synchronise serial input, take after clock high
// - Serial output registered, delayed after clock validation
// - Trace clock rises centred in data window
// - Quiet bit freezes trace clock and outputs
// - Clearing quiet restores toggling; probe resynchronises
// - Trace clock idle until first start code
// - Status output follows core clock, not bus
// - All-ones flag is AND of status bits
// - Data output shows captured data, breakpoint status
// - Accept serial clock after two equal samples
// - On serial clock rise sample input, shift output
`include "dtsp_map.vh"

module dtsp_top #(
  parameter FRAME_W = `DTSP_FRAME_W,
  parameter STATUS_W = `DTSP_STATUS_W
) (
  input wire core_clk, // Processor clock
  input wire srst, // Synchronous reset, high
  input wire clkEn, // Freezes all state while low
  input wire debugSerialClock, // Serial clock pin from probe
  input wire debugSerialIn, // Serial data pin from probe
  input wire breakpointRequest, // Manual halt request pin
  input wire traceQuietBit, // Quiet control from config register
  input wire resetExceptionActive, // Core runs reset exception
  input wire resumeRequest, // Core leaves halted state
  input wire [STATUS_W-1:0] coreStatusIn, // Status from core
  input wire [STATUS_W-1:0] coreDataIn, // Captured data from core
  input wire coreDataValid, // Captured data offered
  output wire coreDataReady, // Buffer can take data
  input wire [FRAME_W-1:0] respWord, // Response to send
  input wire respLoad, // Load response, pulse
  output reg respTaken, // Response loaded, pulse
  output reg [FRAME_W-1:0] cmdWord, // Received command
  output reg cmdValid, // Command complete, pulse
  output reg debugSerialOut, // Serial data pin to probe
  output reg traceSampleClock, // Trace sampling clock
  output reg [STATUS_W-1:0] coreStatusCode, // Status pins
  output reg [STATUS_W-1:0] traceDebugData, // Debug data pins
  output reg allStatusOnes, // AND of status pins
  output reg haltedState // Core halted by breakpoint
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  // At least one cycle, so the pin never moves at the edge event itself
  localparam integer OUT_DELAY_I = (`DTSP_OUT_DELAY_CYC < 1) ? 1 :
    `DTSP_OUT_DELAY_CYC; // Cycles from clock validation to output
  localparam [7:0] OUT_DELAY = OUT_DELAY_I[7:0]; // Delay counter load
  // Bit count reached at the last edge of a frame
  localparam integer LAST_BIT_I = FRAME_W - 1; // Index of final bit
  localparam [`DTSP_BITCNT_W-1:0] LAST_BIT =
    LAST_BIT_I[`DTSP_BITCNT_W-1:0]; // Counter value at final edge
  localparam [2:0] ST_IDLE = 3'b001; // Waiting for frame
  localparam [2:0] ST_SHIFT = 3'b010; // Bits moving
  localparam [2:0] ST_DONE = 3'b100; // Frame complete

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  wire [2:0] pinSync; // Synchronised clock, data, breakpoint
  reg sclkPrev_reg; // Previous synchronised serial clock
  wire sclkRise; // Validated rising edge
  wire sdin; // Validated serial input
  wire bkptSync; // Validated breakpoint level

  // Serial clock, input and breakpoint pass the filter
  // All three see the same latency, so setup of data against clock
  // at the pins carries through to the synchronised copies
  dtsp_sync #(
    .WIDTH(3),
    .RST_VAL(3'h0)
  ) uSync (
    .core_clk(core_clk),
    .srst(srst),
    .clkEn(clkEn),
    .pinIn({breakpointRequest, debugSerialIn, debugSerialClock}),
    .syncOut(pinSync)
  );

  assign sdin = pinSync[1];
  assign bkptSync = pinSync[2];
  assign sclkRise = pinSync[0] && !sclkPrev_reg;

  // ----------------------------------------------------------------------
  // Serial link state
  // ----------------------------------------------------------------------
  reg [2:0] state_reg; // Frame state, one-hot
  reg [2:0] state_next; // Next frame state
  reg [`DTSP_BITCNT_W-1:0] bitCnt_reg; // Bits received in frame
  reg [FRAME_W-1:0] rxShift_reg; // Incoming bits
  reg [FRAME_W-1:0] txShift_reg; // Outgoing bits
  reg [7:0] outDelay_reg; // Delay to output update
  reg outPending_reg; // Output update waiting
  reg txBit_reg; // Next bit for the output pin

  // Next state of the frame machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sclkRise) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // No timeout: a cut frame waits here for its missing edges
        if (sclkRise && bitCnt_reg == LAST_BIT) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Shift bits on each validated rising serial clock
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      sclkPrev_reg <= 1'b0;
      bitCnt_reg <= {`DTSP_BITCNT_W{1'b0}};
      rxShift_reg <= {FRAME_W{1'b0}};
      txShift_reg <= {FRAME_W{1'b0}};
      cmdWord <= {FRAME_W{1'b0}};
      cmdValid <= 1'b0;
      respTaken <= 1'b0;
      txBit_reg <= `DTSP_DSO_RST;
    end else if (clkEn) begin
      state_reg <= state_next;
      sclkPrev_reg <= pinSync[0];
      cmdValid <= 1'b0;
      respTaken <= 1'b0;
      // Response loads only between frames
      if (respLoad && state_reg == ST_IDLE && !sclkRise) begin
        txShift_reg <= respWord;
        respTaken <= 1'b1;
      end
      if (sclkRise) begin
        rxShift_reg <= {rxShift_reg[FRAME_W-2:0], sdin};
        txBit_reg <= txShift_reg[FRAME_W-1];
        txShift_reg <= {txShift_reg[FRAME_W-2:0], 1'b0};
        if (state_reg == ST_IDLE) begin
          bitCnt_reg <= {{(`DTSP_BITCNT_W-1){1'b0}}, 1'b1};
        end else begin
          bitCnt_reg <= bitCnt_reg + 1'b1;
        end
      end
      // Whole frame handed to the core
      if (state_reg == ST_DONE) begin
        cmdWord <= rxShift_reg;
        cmdValid <= 1'b1;
        bitCnt_reg <= {`DTSP_BITCNT_W{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Delayed serial output register
  // ----------------------------------------------------------------------
  // Pin changes a fixed delay after the clock high is validated
  always @(posedge core_clk) begin
    if (srst) begin
      outDelay_reg <= 8'h00;
      outPending_reg <= 1'b0;
      debugSerialOut <= `DTSP_DSO_RST;
    end else if (clkEn) begin
      if (sclkRise) begin
        outDelay_reg <= OUT_DELAY;
        outPending_reg <= 1'b1;
      end else if (outPending_reg) begin
        if (outDelay_reg == 8'h01) begin
          debugSerialOut <= txBit_reg;
          outPending_reg <= 1'b0;
        end
        outDelay_reg <= outDelay_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Breakpoint halt
  // ----------------------------------------------------------------------
  // Halt set by breakpoint wins over a resume in the same cycle
  // A request still held keeps the core halted, so resume acts only
  // once the synchronised request has fallen
  always @(posedge core_clk) begin
    if (srst) begin
      haltedState <= 1'b0;
    end else if (clkEn) begin
      if (bkptSync) begin
        haltedState <= 1'b1;
      end else if (resumeRequest) begin
        haltedState <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Captured data buffer
  // ----------------------------------------------------------------------
  wire [STATUS_W-1:0] bufData; // Word at buffer head
  wire bufValid; // Buffer holds a word
  wire bufReady; // Trace side takes a word
  reg quiet_reg; // Registered quiet control
  reg phase_reg; // Trace half-period phase
  reg started_reg; // Trace clock released

  // Words drain only on the launch phase of a running, loud trace
  // A stalled trace fills both entries and drops ready, so the core
  // holds its word rather than losing it
  assign bufReady = started_reg && !quiet_reg && !phase_reg &&
    !haltedState;

  dtsp_buf2 #(
    .WIDTH(STATUS_W)
  ) uBuf (
    .core_clk(core_clk),
    .srst(srst),
    .clkEn(clkEn),
    .inData(coreDataIn),
    .inValid(coreDataValid),
    .inReady(coreDataReady),
    .outData(bufData),
    .outValid(bufValid),
    .outReady(bufReady)
  );

  // ----------------------------------------------------------------------
  // Trace start and quiet control
  // ----------------------------------------------------------------------
  // Release the trace clock on the first start code in reset exception
  // Quiet is registered, so the outputs freeze one cycle after it sets
  always @(posedge core_clk) begin
    if (srst) begin
      started_reg <= 1'b0;
      quiet_reg <= `DTSP_QUIET_RST;
    end else if (clkEn) begin
      quiet_reg <= traceQuietBit;
      if (resetExceptionActive &&
          (coreStatusIn == `DTSP_START_C ||
           coreStatusIn == `DTSP_START_D ||
           coreStatusIn == `DTSP_START_F)) begin
        started_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trace outputs
  // ----------------------------------------------------------------------
  // Data and status launch on phase 0, clock rises on phase 1,
  // so the rising edge sits in the middle of each two-cycle window
  // Quiet has priority, so a stalled trace holds every output as is
  always @(posedge core_clk) begin
    if (srst) begin
      phase_reg <= 1'b0;
      traceSampleClock <= 1'b0;
      coreStatusCode <= `DTSP_STATUS_IDLE;
      traceDebugData <= `DTSP_DATA_IDLE;
      allStatusOnes <= 1'b0;
    end else if (clkEn) begin
      if (quiet_reg) begin
        phase_reg <= phase_reg;
      end else if (!started_reg) begin
        phase_reg <= 1'b0;
        traceSampleClock <= 1'b0;
        coreStatusCode <= coreStatusIn;
        allStatusOnes <= &coreStatusIn;
      end else begin
        phase_reg <= ~phase_reg;
        traceSampleClock <= phase_reg;
        if (!phase_reg) begin
          if (haltedState) begin
            coreStatusCode <= `DTSP_STATUS_HALT;
            traceDebugData <= `DTSP_STATUS_HALT;
            allStatusOnes <= 1'b1;
          end else begin
            coreStatusCode <= coreStatusIn;
            allStatusOnes <= &coreStatusIn;
            if (bufValid) begin
              traceDebugData <= bufData;
            end else begin
              traceDebugData <= `DTSP_DATA_IDLE;
            end
          end
        end
      end
    end
  end

endmodule // dtsp_top

/* File: dv/dtsp_top_asserts.sv */
// Assertion checker for the debug trace and serial port
module dtsp_top_asserts #(
  parameter FRAME_W = 17,
  parameter STATUS_W = 4
) (
  input wire core_clk,
  input wire srst,
  input wire clkEn,
  input wire debugSerialClock,
  input wire breakpointRequest,
  input wire traceQuietBit,
  input wire resetExceptionActive,
  input wire [STATUS_W-1:0] coreStatusIn,
  input wire respLoad,
  input wire respTaken,
  input wire cmdValid,
  input wire debugSerialOut,
  input wire traceSampleClock,
  input wire [STATUS_W-1:0] coreStatusCode,
  input wire [STATUS_W-1:0] traceDebugData,
  input wire allStatusOnes,
  input wire haltedState
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Start tracking
  // ------------------------------------------------------------
  reg startSeen_reg; // A start code has been taken
  // Set once a start code meets reset exception processing
  always @(posedge core_clk) begin
    if (srst)
      startSeen_reg <= 1'h0;
    else if (clkEn && resetExceptionActive && (coreStatusIn == 4'hC ||
             coreStatusIn == 4'hD || coreStatusIn == 4'hF))
      startSeen_reg <= 1'h1;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_clock_idle: assert property (!startSeen_reg |-> !traceSampleClock)
    else $error("trace clock moved before start");
  a_all_ones: assert property (allStatusOnes == &coreStatusCode)
    else $error("all-ones flag differs from status AND");
  a_quiet_freeze: assert property (traceQuietBit [*3] |->
    $stable(traceSampleClock) && $stable(coreStatusCode) &&
    $stable(traceDebugData))
    else $error("trace outputs moved while quiet");
  a_rise_centred: assert property ($rose(traceSampleClock) |->
    $stable(coreStatusCode) && $stable(traceDebugData))
    else $error("trace data changed at clock rise");
  a_serial_out_late: assert property ($changed(debugSerialOut) |->
    $past(debugSerialClock, 3) && $past(debugSerialClock, 4))
    else $error("serial output moved without a valid clock high");
  a_cmd_after_clock: assert property (cmdValid |->
    $past(debugSerialClock, 3) && $past(debugSerialClock, 4))
    else $error("command completed without a valid clock high");
  a_cmd_pulse: assert property (cmdValid && clkEn |=> !cmdValid)
    else $error("command strobe longer than one cycle");
  a_resp_cause: assert property ($rose(respTaken) |-> $past(respLoad))
    else $error("response taken without a load");
  a_resp_pulse: assert property (respTaken && clkEn |=> !respTaken)
    else $error("response strobe longer than one cycle");
  a_halt_shows_f: assert property (
    (haltedState && clkEn && !traceQuietBit) [*6] |->
    coreStatusCode == 4'hF && traceDebugData == 4'hF)
    else $error("halt not shown as all ones");
  a_halt_cause: assert property ($rose(haltedState) |->
    $past(breakpointRequest, 2))
    else $error("halt without a breakpoint request");
  // Main scenarios
  c_started: cover property ($rose(traceSampleClock));
  c_command: cover property (cmdValid);
  c_halted: cover property ($rose(haltedState));
endmodule // dtsp_top_asserts

bind dtsp_top dtsp_top_asserts #(.FRAME_W(FRAME_W), .STATUS_W(STATUS_W))
  u_chk (.core_clk, .srst, .clkEn, .debugSerialClock, .breakpointRequest,
  .traceQuietBit, .resetExceptionActive, .coreStatusIn, .respLoad,
  .respTaken, .cmdValid, .debugSerialOut, .traceSampleClock,
  .coreStatusCode, .traceDebugData, .allStatusOnes, .haltedState);

/* File: dv/dtsp_probe.sv */
// Development system model: serial link master and trace capture
module dtsp_probe (
  output logic debugSerialClock,
  output logic debugSerialIn,
  input wire debugSerialOut,
  input wire traceSampleClock,
  input wire [3:0] traceDebugData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] seen[$]; // Data words caught on the trace, other than 0 and F
  // Serial lines idle: clock low, data parked
  initial begin
    debugSerialClock = 1'h0;
    debugSerialIn = 1'h1;
  end
  // ------------------------------------------------------------
  // Trace capture, resynchronised by the clock rise alone
  // ------------------------------------------------------------
  always @(posedge traceSampleClock) begin
    if (traceDebugData != 4'h0 && traceDebugData != 4'hF)
      seen.push_back(traceDebugData);
  end
  // ------------------------------------------------------------
  // One 17-bit frame, MSB first, 64 ns period; optional glitch
  // ------------------------------------------------------------
  task automatic xfer(input logic g, input logic [16:0] cmd,
                      output logic [16:0] rsp);
    if (g) begin
      debugSerialClock = 1'h1;
      #4;
      debugSerialClock = 1'h0;
      #30;
    end
    debugSerialIn = cmd[16];
    #16;
    for (int i = 16; i >= 0; i--) begin
      debugSerialClock = 1'h1;
      #32;
      debugSerialClock = 1'h0;
      #16;
      // Next bit mid-low; after the frame the line shows the inverse
      debugSerialIn = (i > 0) ? cmd[i-1] : ~cmd[0];
      #15;
      rsp[i] = debugSerialOut;
      #1;
    end
  endtask
endmodule // dtsp_probe

/* File: dv/dtsp_top_bench.sv */
// Self-checking testbench of the debug trace and serial port
`include "dtsp_map.vh"
module dtsp_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0;
  logic srst, clkEn, breakpointRequest, traceQuietBit, resumeRequest;
  logic resetExceptionActive, coreDataValid, respLoad;
  logic [3:0] coreStatusIn, coreDataIn, v;
  logic [16:0] respWord, cmd, res, rsp;
  logic [8:0] snap; // Trace outputs before a freeze
  logic [3:0] sent[$]; // Words offered to the trace buffer
  wire debugSerialClock, debugSerialIn, coreDataReady, respTaken;
  wire cmdValid, debugSerialOut, traceSampleClock, allStatusOnes;
  wire haltedState;
  wire [16:0] cmdWord;
  wire [3:0] coreStatusCode, traceDebugData;
  integer fails = 0;
  integer num_checks = 0;
  integer seed = 13373;
  integer k, n;
  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;
  dtsp_top u_dut (.core_clk, .srst, .clkEn, .debugSerialClock,
    .debugSerialIn, .breakpointRequest, .traceQuietBit,
    .resetExceptionActive, .resumeRequest, .coreStatusIn, .coreDataIn,
    .coreDataValid, .coreDataReady, .respWord, .respLoad, .respTaken,
    .cmdWord, .cmdValid, .debugSerialOut, .traceSampleClock,
    .coreStatusCode, .traceDebugData, .allStatusOnes, .haltedState);
  dtsp_probe u_probe (.debugSerialClock, .debugSerialIn, .debugSerialOut,
    .traceSampleClock, .traceDebugData);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] rnd(input integer m);
    return 4'(1 + $unsigned($random(seed)) % m);
  endfunction
  task check(input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge core_clk);
  endtask
  // Reset, then walk the pre-start phase up to a start code
  task start(input logic [3:0] code);
    srst = 1'h1;
    cyc(3);
    srst = 1'h0;
    resetExceptionActive = 1'h1;
    for (k = 0; k < 8; k++) begin
      v = rnd(11);
      coreStatusIn = v;
      cyc(1);
      check(coreStatusCode, v);
      check(traceSampleClock, 0);
    end
    coreStatusIn = code;
    for (n = 0; n < 10 && traceSampleClock !== 1'h1; n++)
      cyc(1);
    check(traceSampleClock, 1);
    resetExceptionActive = 1'h0;
  endtask
  // Offer one word; valid stays up for back-to-back offers
  task push(input logic [3:0] w);
    coreDataIn = w;
    coreDataValid = 1'h1;
    coreStatusIn = 4'($random(seed));
    sent.push_back(w);
    for (n = 0; n < 200 && coreDataReady !== 1'h1; n++)
      cyc(1);
    cyc(1);
  endtask
  task load(input logic [16:0] w, input logic ok);
    respWord = w;
    respLoad = 1'h1;
    cyc(1);
    respLoad = 1'h0;
    check(respTaken, ok);
  endtask
  // Watchdog
  initial begin
    #60000;
    fails++;
    end_sim;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {clkEn, breakpointRequest, traceQuietBit, resumeRequest} = 4'h8;
    {coreDataValid, respLoad, coreDataIn, respWord} = 23'h0;
    start(`DTSP_START_C);
    start(`DTSP_START_D);
    start(`DTSP_START_F);
    // Quiet stall: buffer fills and refuses, outputs freeze
    traceQuietBit = 1'h1;
    cyc(3);
    u_probe.seen.delete();
    snap = {traceSampleClock, coreStatusCode, traceDebugData};
    push(rnd(14));
    push(rnd(14));
    check(coreDataReady, 0);
    cyc(6);
    check({traceSampleClock, coreStatusCode, traceDebugData}, snap);
    traceQuietBit = 1'h0;
    repeat (12)
      push(rnd(14));
    coreDataValid = 1'h0;
    clkEn = 1'h0;
    cyc(4);
    clkEn = 1'h1;
    cyc(60);
    check(u_probe.seen.size(), sent.size());
    foreach (sent[j])
      check(u_probe.seen[j], sent[j]);
    // Serial frames, one with a glitch, one with a refused load
    for (int f = 0; f < 4; f++) begin
      res = 17'($random(seed));
      cmd = 17'($random(seed));
      load(res, 1);
      fork
        u_probe.xfer(f == 1, cmd, rsp);
        begin
          for (n = 0; n < 400 && cmdValid !== 1'h1; n++)
            cyc(1);
          check(cmdWord, cmd);
        end
        if (f == 2) begin
          cyc(100);
          load(~res, 0);
        end
      join
      cyc(1);
      check(rsp, res);
    end
    // Breakpoint halt and resume
    breakpointRequest = 1'h1;
    for (n = 0; n < 20 && haltedState !== 1'h1; n++)
      cyc(1);
    cyc(8);
    check({coreStatusCode, traceDebugData, allStatusOnes},
          {`DTSP_STATUS_HALT, `DTSP_STATUS_HALT, 1'h1});
    breakpointRequest = 1'h0;
    resumeRequest = 1'h1;
    for (n = 0; n < 20 && haltedState !== 1'h0; n++)
      cyc(1);
    resumeRequest = 1'h0;
    check(haltedState, 0);
    end_sim;
  end
endmodule // dtsp_top_bench
